// file: core/eepb_pkg.sv
// eepb_pkg: constants and types shared by both ends of the two-wire eeprom link
// assumes a 50 MHz ref_clk on both ends
package eepb_pkg;
  localparam int unsigned REF_CLK_NS    = 20;
  // internal_write_cycle_time, standard and lowest-voltage options
  localparam int unsigned WR_TIME_MS    = 10;
  localparam int unsigned WR_LOWV_MS    = 20;
  localparam int unsigned WR_TIME_CLKS  = WR_TIME_MS * 1000000 / REF_CLK_NS;
  localparam int unsigned WR_CNT_W      = 20;
  // controller-made serial clock, quarter period steps
  localparam int unsigned SCL_PERIOD_NS = 10000;
  localparam int unsigned QTR_CYCLES    = SCL_PERIOD_NS / (4 * REF_CLK_NS);
  localparam int unsigned QTR_W         = 8;
  localparam int unsigned MEM_AW        = 12;
  localparam int unsigned MEM_DEPTH     = 4096;
  localparam int unsigned PAGE_AW       = 5;
  localparam int unsigned PAGE_BYTES    = 32;
  localparam logic [3:0]  BIT_ACK       = 4'h8;
  localparam logic [3:0]  BIT_END       = 4'h9;
  localparam logic [3:0]  RECOV_PROBES  = 4'h9;
  localparam logic [3:0]  DEV_CODE      = 4'ha;
  localparam logic [1:0]  WP_QUADRANT   = 2'h3;
  localparam logic [5:0]  SYNC_RST      = 6'h30;
  // controller register map (apb, byte addresses)
  localparam logic [7:0]  REG_CTRL      = 8'h00;
  localparam logic [7:0]  REG_ADDR      = 8'h04;
  localparam logic [7:0]  REG_WDATA     = 8'h08;
  localparam logic [7:0]  REG_STATUS    = 8'h0c;
  localparam logic [7:0]  REG_RDATA     = 8'h10;
  localparam int unsigned CTRL_GO       = 0;
  localparam int unsigned CTRL_MODE     = 1;
  localparam int unsigned CTRL_CS       = 4;
  localparam int unsigned ST_BUSY       = 0;
  localparam int unsigned ST_NACK       = 1;
  localparam int unsigned ST_DONE       = 2;
  localparam int unsigned ST_RECFAIL    = 3;

  typedef enum logic [1:0] {
    MODE_WRITE = 2'h0, MODE_RREAD = 2'h1, MODE_CREAD = 2'h2, MODE_RECOV = 2'h3
  } eepb_mode_e;

  typedef enum logic [6:0] {
    T_IDLE = 7'h01, T_DEVADR = 7'h02, T_ADRHI = 7'h04, T_ADRLO = 7'h08,
    T_WRDATA = 7'h10, T_RDDATA = 7'h20, T_BUSY = 7'h40
  } eepb_tstate_e;

  typedef enum logic [1:0] {H_IDLE = 2'h1, H_RUN = 2'h2} eepb_hstate_e;

  typedef enum logic [2:0] {
    OP_START = 3'h0, OP_TX = 3'h1, OP_RX = 3'h2, OP_STOP = 3'h3, OP_PROBE = 3'h4
  } eepb_op_e;
endpackage

// file: core/eepb_if.sv
// eepb_if: the two-wire link between controller and eeprom target
// assumes open-drain data: a party pulls low while its enable is high
`timescale 1ns/1ns
interface eepb_if;
  logic scl;
  logic hostSdaOut;
  logic hostSdaOe;
  logic devSdaOut;
  logic devSdaOe;
  logic sda;

  // wired-and of both drivers, pulled high when released
  assign sda = !((hostSdaOe && !hostSdaOut) || (devSdaOe && !devSdaOut));

  modport device (input scl, input sda, output devSdaOut, output devSdaOe);
  modport host (output scl, output hostSdaOut, output hostSdaOe, input sda);
endinterface

// file: core/eepb_target.sv
// eepb_target: two-wire eeprom target with 4096 x 8 flip-flop array
// assumes scl and sda arrive unsynchronised through eepb_if, ref_clk 50 MHz
// Behaviour
// - data change with clock high is condition
// - sda falls, scl high: start, any state but the busy write cycle
// - sda rises, scl high: stop ends operation
// - stop after read returns to standby
// - 8-bit words, ack low on ninth clock
// - standby at power-up and after stop, once any write cycle ends
// - controller recovers: clocks until data is high (nine at most), then start
// - device address word follows every start
// - top four address bits must be 1010
// - next three bits match chip selects
// - unconnected chip select reads as low; here pins are sampled as driven, low only from the synchroniser reset
// - eighth address bit: one read, zero write
// - matching address is acknowledged low
// - mismatch: no ack, standby until start
// - write protect blocks upper quarter writes
// - write cycle from stop, within limit
// - write: two address bytes, data, stop
// - page write wraps in lower five bits
// - busy write cycle ignores bus, no ack
// - read continues while acked, wraps around
`timescale 1ns/1ns
module eepb_target #(
  parameter int unsigned WR_CYCLES = eepb_pkg::WR_TIME_CLKS
) (
  input  wire logic ref_clk,
  input  wire logic reset_n,
  eepb_if.device    bus,
  input  wire logic chip_select_bit2,
  input  wire logic chip_select_bit1,
  input  wire logic chip_select_bit0,
  input  wire logic writeProtect,
  output logic      standby,
  output logic      writeBusy
);
  import eepb_pkg::*;

  logic [5:0]           sync1_r;
  logic [5:0]           sync2_r;
  logic                 sclD_r;
  logic                 sdaD_r;
  logic                 sclS;
  logic                 sdaS;
  logic                 wpS;
  logic [2:0]           csS;
  logic                 sclRise;
  logic                 sclFall;
  logic                 startDet;
  logic                 stopDet;
  logic                 byteEnd;
  logic                 frameEnd;
  logic                 addrMatch;
  eepb_tstate_e         state_r;
  logic [3:0]           bitCnt_r;
  logic [7:0]           shift_r;
  logic [7:0]           txByte_r;
  logic                 ackIn_r;
  logic                 sdaOe_r;
  logic [MEM_AW-1:0]    addr_r;
  logic [7:0]           mem     [MEM_DEPTH];
  logic [7:0]           pageBuf_r [PAGE_BYTES];
  logic [PAGE_BYTES-1:0] pageVal_r;
  logic [WR_CNT_W-1:0]  wrCnt_r;
  logic                 wrDone;
  logic                 standby_r;
  logic                 writeBusy_r;
  logic                 sdaOut_r;

  // two-stage synchronisers for all pins; chip selects reset low
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      sync1_r <= SYNC_RST;
      sync2_r <= SYNC_RST;
    end else begin
      sync1_r <= {bus.scl, bus.sda, writeProtect,
                  chip_select_bit2, chip_select_bit1, chip_select_bit0};
      sync2_r <= sync1_r;
    end
  end

  // delayed copies for edge finding
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      sclD_r <= 1'b1;
      sdaD_r <= 1'b1;
    end else begin
      sclD_r <= sclS;
      sdaD_r <= sdaS;
    end
  end

  assign sclS = sync2_r[5];
  assign sdaS = sync2_r[4];
  assign wpS  = sync2_r[3];
  assign csS  = sync2_r[2:0];

  // bus events; sda moving with scl high is a condition
  assign sclRise  = sclS && !sclD_r;
  assign sclFall  = !sclS && sclD_r;
  assign startDet = sclS && sclD_r && sdaD_r && !sdaS;
  assign stopDet  = sclS && sclD_r && !sdaD_r && sdaS;
  assign byteEnd  = sclFall && (bitCnt_r == BIT_ACK) && !startDet && !stopDet;
  assign frameEnd = sclFall && (bitCnt_r == BIT_END);

  // device address word: fixed code, chip selects, r/w in bit 0
  assign addrMatch = (shift_r[7:4] == DEV_CODE) &&
                     (shift_r[3:1] == csS);

  // write cycle timer runs only in the busy state
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      wrCnt_r <= '0;
    end else if (state_r != T_BUSY) begin
      wrCnt_r <= '0;
    end else begin
      wrCnt_r <= wrCnt_r + 1'b1;
    end
  end

  assign wrDone = (state_r == T_BUSY) &&
                  (wrCnt_r == WR_CNT_W'(WR_CYCLES - 1));

  // protocol engine
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      state_r  <= T_IDLE;
      bitCnt_r <= '0;
      shift_r  <= '0;
      txByte_r <= '0;
      ackIn_r  <= 1'b1;
      sdaOe_r  <= 1'b0;
      addr_r   <= '0;
    end else if (state_r == T_BUSY) begin
      // all inputs ignored while writing
      sdaOe_r <= 1'b0;
      if (wrDone) begin
        state_r <= T_IDLE;
      end
    end else if (startDet) begin
      state_r  <= T_DEVADR;
      bitCnt_r <= '0;
      sdaOe_r  <= 1'b0;
    end else if (stopDet) begin
      bitCnt_r <= '0;
      sdaOe_r  <= 1'b0;
      if (state_r == T_WRDATA && pageVal_r != '0) begin
        state_r <= T_BUSY;
      end else begin
        state_r <= T_IDLE;
      end
    end else if (state_r != T_IDLE) begin
      if (sclRise) begin
        // sample on the rising edge, msb first
        if (bitCnt_r < BIT_ACK) begin
          shift_r <= {shift_r[6:0], sdaS};
        end else begin
          ackIn_r <= sdaS;
        end
        bitCnt_r <= bitCnt_r + 1'b1;
      end else if (byteEnd) begin
        case (state_r)
          T_DEVADR: begin
            if (addrMatch) begin
              sdaOe_r <= 1'b1;
              state_r <= shift_r[0] ? T_RDDATA : T_ADRHI;
            end else begin
              state_r <= T_IDLE;
            end
          end
          T_ADRHI: begin
            addr_r[MEM_AW-1:8] <= shift_r[MEM_AW-9:0];
            sdaOe_r            <= 1'b1;
            state_r            <= T_ADRLO;
          end
          T_ADRLO: begin
            addr_r[7:0] <= shift_r;
            sdaOe_r     <= 1'b1;
            state_r     <= T_WRDATA;
          end
          T_WRDATA: begin
            sdaOe_r                <= 1'b1;
            addr_r[PAGE_AW-1:0]    <= addr_r[PAGE_AW-1:0] + 1'b1;
          end
          T_RDDATA: begin
            // release for the controller's ack, step the address
            sdaOe_r <= 1'b0;
            addr_r  <= addr_r + 1'b1;
          end
          default: begin
            sdaOe_r <= 1'b0;
          end
        endcase
      end else if (frameEnd) begin
        bitCnt_r <= '0;
        // our own ack slot, or the controller acked: send next byte
        if (state_r == T_RDDATA && (sdaOe_r || !ackIn_r)) begin
          txByte_r <= mem[addr_r];
          sdaOe_r  <= !mem[addr_r][7];
        end else begin
          sdaOe_r <= 1'b0;
          if (state_r == T_RDDATA) begin
            state_r <= T_IDLE;
          end
        end
      end else if (sclFall && state_r == T_RDDATA && bitCnt_r != '0) begin
        // change data after the falling edge
        sdaOe_r <= !txByte_r[3'(7 - bitCnt_r)];
      end
    end
  end

  // page buffer collects data bytes until the stop
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      pageVal_r <= '0;
    end else if (byteEnd && state_r == T_ADRLO) begin
      pageVal_r <= '0;
    end else if (byteEnd && state_r == T_WRDATA) begin
      if (!(wpS && addr_r[MEM_AW-1:MEM_AW-2] == WP_QUADRANT)) begin
        pageVal_r[addr_r[PAGE_AW-1:0]] <= 1'b1;
      end
    end else if (wrDone) begin
      pageVal_r <= '0;
    end
  end

  // buffered data, no reset needed
  always_ff @(posedge ref_clk) begin
    if (byteEnd && state_r == T_WRDATA) begin
      pageBuf_r[addr_r[PAGE_AW-1:0]] <= shift_r;
    end
  end

  // array update at the end of the write cycle
  always_ff @(posedge ref_clk) begin
    for (int i = 0; i < PAGE_BYTES; i++) begin
      if (wrDone && pageVal_r[i]) begin
        mem[{addr_r[MEM_AW-1:PAGE_AW], PAGE_AW'(i)}] <= pageBuf_r[i];
      end
    end
  end

  // registered status and pin outputs
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      standby_r   <= 1'b1;
      writeBusy_r <= 1'b0;
      sdaOut_r    <= 1'b0;
    end else begin
      standby_r   <= (state_r == T_IDLE);
      writeBusy_r <= (state_r == T_BUSY);
      sdaOut_r    <= 1'b0;
    end
  end

  assign standby       = standby_r;
  assign writeBusy     = writeBusy_r;
  assign bus.devSdaOe  = sdaOe_r;
  assign bus.devSdaOut = sdaOut_r;
endmodule

// file: core/eepb_controller.sv
// eepb_controller: two-wire bus controller ordered over apb registers
// assumes apb on ref_clk; drives scl push-pull, sda open-drain via eepb_if
`timescale 1ns/1ns
module eepb_controller (
  input  wire logic  ref_clk,
  input  wire logic  reset_n,
  eepb_if.host       bus,
  input  wire logic  psel,
  input  wire logic  penable,
  input  wire logic  pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic       pready,
  output logic       pslverr
);
  import eepb_pkg::*;

  logic              pready_r;
  logic              pslverr_r;
  logic [31:0]       prdata_r;
  logic [31:0]       rdMux;
  logic              mapped;
  logic              wrAcc;
  logic              go;
  eepb_mode_e        mode_r;
  logic [2:0]        cs_r;
  logic [MEM_AW-1:0] addr_r;
  logic [7:0]        wdata_r;
  logic [7:0]        rdata_r;
  logic              nack_r;
  logic              done_r;
  logic              recFail_r;
  eepb_hstate_e      state_r;
  logic [QTR_W-1:0]  qtr_r;
  logic              tick;
  logic [1:0]        ph_r;
  logic [2:0]        step_r;
  logic [3:0]        bitIdx_r;
  logic [3:0]        probes_r;
  logic              abort_r;
  logic [8:0]        rx_r;
  logic [1:0]        sdaSync_r;
  logic              scl_r;
  logic              sdaOe_r;
  eepb_op_e          op;
  logic [7:0]        txb;
  logic              isBit;
  logic              slotEnd;

  // apb slave: one wait state, writes land when pready is high
  assign wrAcc = psel && penable && pready_r && pwrite;
  assign go    = wrAcc && paddr == REG_CTRL && pwdata[CTRL_GO] && state_r == H_IDLE;

  always_comb begin
    mapped = 1'b1;
    case (paddr)
      REG_CTRL:   rdMux = {25'h0, cs_r, 1'b0, mode_r, 1'b0};
      REG_ADDR:   rdMux = {20'h0, addr_r};
      REG_WDATA:  rdMux = {24'h0, wdata_r};
      REG_STATUS: rdMux = {28'h0, recFail_r, done_r, nack_r, state_r == H_RUN};
      REG_RDATA:  rdMux = {24'h0, rdata_r};
      default: begin
        rdMux  = 32'h0;
        mapped = 1'b0;
      end
    endcase
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      pready_r  <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r  <= 32'h0;
    end else begin
      pready_r  <= psel && penable && !pready_r;
      pslverr_r <= psel && penable && !pready_r && !mapped;
      if (psel && penable && !pready_r) begin
        prdata_r <= pwrite ? 32'h0 : rdMux;
      end
    end
  end

  // command registers
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      mode_r  <= MODE_WRITE;
      cs_r    <= '0;
      addr_r  <= '0;
      wdata_r <= '0;
    end else if (wrAcc) begin
      case (paddr)
        REG_CTRL: begin
          mode_r <= eepb_mode_e'(pwdata[CTRL_MODE +: 2]);
          cs_r   <= pwdata[CTRL_CS +: 3];
        end
        REG_ADDR:  addr_r  <= pwdata[MEM_AW-1:0];
        REG_WDATA: wdata_r <= pwdata[7:0];
        default: begin
        end
      endcase
    end
  end

  // op sequence of each command
  always_comb begin
    op = OP_STOP;
    if (!abort_r) begin
      case (mode_r)
        MODE_WRITE: op = (step_r == 3'd0) ? OP_START : (step_r < 3'd5) ? OP_TX : OP_STOP;
        MODE_RREAD: begin
          case (step_r)
            3'd0, 3'd4: op = OP_START;
            3'd6:       op = OP_RX;
            3'd7:       op = OP_STOP;
            default:    op = OP_TX;
          endcase
        end
        MODE_CREAD: op = (step_r == 3'd0) ? OP_START : (step_r == 3'd1) ? OP_TX :
                         (step_r == 3'd2) ? OP_RX : OP_STOP;
        default:    op = (step_r == 3'd0) ? OP_PROBE : (step_r == 3'd1) ? OP_START : OP_STOP;
      endcase
    end
    case (step_r)
      3'd1:    txb = {DEV_CODE, cs_r, mode_r == MODE_CREAD};
      3'd2:    txb = {4'h0, addr_r[MEM_AW-1:8]};
      3'd3:    txb = addr_r[7:0];
      3'd4:    txb = wdata_r;
      default: txb = {DEV_CODE, cs_r, 1'b1};
    endcase
  end

  assign isBit   = (op == OP_TX) || (op == OP_RX) || (op == OP_PROBE);
  assign tick    = (qtr_r == '0);
  assign slotEnd = tick && ph_r == 2'd3;

  // sda synchroniser
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      sdaSync_r <= 2'b11;
    end else begin
      sdaSync_r <= {sdaSync_r[0], bus.sda};
    end
  end

  // quarter-period divider makes scl
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      qtr_r <= QTR_W'(QTR_CYCLES - 1);
    end else if (state_r == H_IDLE || tick) begin
      qtr_r <= QTR_W'(QTR_CYCLES - 1);
    end else begin
      qtr_r <= qtr_r - 1'b1;
    end
  end

  // bit engine and sequencer
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      state_r <= H_IDLE;
      ph_r <= '0;
      step_r <= '0;
      bitIdx_r <= '0;
      probes_r <= '0;
      abort_r <= 1'b0;
      rx_r <= '1;
      scl_r <= 1'b1;
      sdaOe_r <= 1'b0;
      nack_r <= 1'b0;
      done_r <= 1'b0;
      recFail_r <= 1'b0;
      rdata_r <= '0;
    end else if (go) begin
      state_r <= H_RUN;
      {ph_r, step_r, bitIdx_r, probes_r} <= '0;
      {abort_r, nack_r, done_r, recFail_r} <= 4'h0;
    end else if (state_r == H_RUN && tick) begin
      ph_r <= ph_r + 1'b1;
      case (ph_r)
        // data set while scl low, msb first
        2'd0: sdaOe_r <= (op == OP_STOP) || (op == OP_TX && bitIdx_r < BIT_ACK &&
                          !txb[3'(7 - bitIdx_r)]);
        2'd1: scl_r <= 1'b1;
        2'd2: begin
          if (isBit) begin
            rx_r <= {rx_r[7:0], sdaSync_r[1]};
          end else begin
            sdaOe_r <= (op == OP_START);
          end
        end
        default: scl_r <= (op == OP_STOP);
      endcase
      if (slotEnd) begin
        if (isBit && op != OP_PROBE && bitIdx_r < BIT_ACK) begin
          bitIdx_r <= bitIdx_r + 1'b1;
        end else begin
          bitIdx_r <= '0;
          if (op == OP_STOP) begin
            state_r <= H_IDLE;
            done_r <= 1'b1;
          end else if (op == OP_TX && rx_r[0]) begin
            abort_r <= 1'b1;
            nack_r <= 1'b1;
          end else if (op == OP_PROBE && !rx_r[0] && probes_r != RECOV_PROBES - 1'b1) begin
            probes_r <= probes_r + 1'b1;
          end else if (op == OP_PROBE && !rx_r[0]) begin
            state_r <= H_IDLE;
            recFail_r <= 1'b1;
            done_r <= 1'b1;
          end else begin
            step_r <= step_r + 1'b1;
            if (op == OP_RX) begin
              rdata_r <= rx_r[8:1];
            end
          end
        end
      end
    end
  end

  assign prdata         = prdata_r;
  assign pready         = pready_r;
  assign pslverr        = pslverr_r;
  assign bus.scl        = scl_r;
  assign bus.hostSdaOe  = sdaOe_r;
  assign bus.hostSdaOut = 1'b0;
endmodule

// file: test/eepb_link_monitor.sv
// eepb_link_monitor: concurrent checks on the two-wire link and target status
// assumes eepb_if signals and target outputs, all in the ref_clk domain
`timescale 1ns/1ns
module eepb_link_monitor #(
  parameter int unsigned WR_CYCLES = 10000
) (
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic scl,
  input wire logic sda,
  input wire logic devSdaOe,
  input wire logic standby,
  input wire logic writeBusy
);
  logic        sdaQ_r;
  logic [7:0]  stopAge_r;
  logic [19:0] busyCnt_r;
  logic        stopSeen;

  default clocking @(posedge ref_clk); endclocking
  default disable iff (!reset_n);

  // stop: data rises while the clock is high
  assign stopSeen = scl && sda && !sdaQ_r;

  // last data level, for edge finding
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      sdaQ_r <= 1'b1;
    end else begin
      sdaQ_r <= sda;
    end
  end

  // cycles since the last stop, saturating
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      stopAge_r <= 8'hff;
    end else if (stopSeen) begin
      stopAge_r <= 8'h00;
    end else if (stopAge_r != 8'hff) begin
      stopAge_r <= stopAge_r + 8'h01;
    end
  end

  // length of the running write cycle
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      busyCnt_r <= 20'h0;
    end else begin
      busyCnt_r <= writeBusy ? busyCnt_r + 20'h1 : 20'h0;
    end
  end

  dev_sda_stable_a: assert property (
    scl && $past(scl) |-> $stable(devSdaOe)) else $error("target moved data with clock high");
  reset_idle_a: assert property (
    $rose(reset_n) |-> standby && !writeBusy && !devSdaOe) else $error("not idle after reset");
  busy_quiet_a: assert property (
    writeBusy |-> !devSdaOe) else $error("target drove data during write cycle");
  busy_not_idle_a: assert property (
    writeBusy |-> !standby) else $error("standby during write cycle");
  busy_len_a: assert property (
    $fell(writeBusy) |-> busyCnt_r >= WR_CYCLES - 1 && busyCnt_r <= WR_CYCLES + 1)
    else $error("write cycle length wrong");
  busy_start_a: assert property (
    $rose(writeBusy) |-> stopAge_r <= 8'h08) else $error("write cycle began without stop");
  bit_stands_a: assert property (
    $rose(devSdaOe) |-> !scl ##1 (devSdaOe throughout (!scl [*1] ##[1:300] scl)))
    else $error("driven bit did not stand over clock high");
  stop_standby_a: assert property (
    stopSeen ##10 !writeBusy |-> standby) else $error("no standby after stop");
  drive_active_a: assert property (
    devSdaOe |-> !standby) else $error("target drove data in standby");
endmodule

// file: test/tb_serial_eeprom_bus_target.sv
// tb_serial_eeprom_bus_target: controller and target joined by eepb_if
// assumes apb answers with one wait state; shortened write cycle
`timescale 1ns/1ns
module tb_serial_eeprom_bus_target;
  import eepb_pkg::*;
  localparam int unsigned WR_CYC = 10000;
  logic        ref_clk;
  logic        reset_n;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [2:0]  csPins;
  logic        writeProtect;
  logic        standby;
  logic        writeBusy;
  logic [31:0] rdVal;
  logic        rdErr;
  int          err_count;
  int          tests_run;

  eepb_if link();
  eepb_target #(.WR_CYCLES(WR_CYC)) eepb_target_inst (.ref_clk(ref_clk), .reset_n(reset_n),
    .bus(link.device), .chip_select_bit2(csPins[2]), .chip_select_bit1(csPins[1]),
    .chip_select_bit0(csPins[0]), .writeProtect(writeProtect), .standby(standby),
    .writeBusy(writeBusy));
  eepb_controller eepb_controller_inst (.ref_clk(ref_clk), .reset_n(reset_n),
    .bus(link.host), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
  eepb_link_monitor #(.WR_CYCLES(WR_CYC)) eepb_link_monitor_inst (.ref_clk(ref_clk),
    .reset_n(reset_n), .scl(link.scl), .sda(link.sda), .devSdaOe(link.devSdaOe),
    .standby(standby), .writeBusy(writeBusy));

  // free-running 50 MHz clock
  always #10 ref_clk = ~ref_clk;

  // verdict and end of run
  task automatic end_sim();
    $display("counts: %0d compares, %0d mismatches", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // compare one flag
  task automatic chk_bit(input string what, input logic exp, input logic got);
    tests_run++;
    if (got !== exp) begin
      err_count++;
      $display("mismatch %s expected %b seen %b", what, exp, got);
    end
  endtask

  // compare one register word
  task automatic chk_word(input string what, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      err_count++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask

  // one apb transfer, held until pready is sampled high
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    int k;
    @(posedge ref_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge ref_clk);
    penable <= 1'b1;
    for (k = 0; k < 20; k++) begin
      @(posedge ref_clk);
      if (pready === 1'b1) break;
    end
    if (k == 20) begin
      err_count++;
      end_sim();
    end
    rdVal = prdata;
    rdErr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // order one link operation and poll status until done
  task automatic run_op(input eepb_mode_e m, input logic [2:0] cs, input logic [11:0] a,
                        input logic [7:0] d);
    int k;
    apb(1'b1, REG_ADDR, {20'h0, a});
    apb(1'b1, REG_WDATA, {24'h0, d});
    apb(1'b1, REG_CTRL, {25'h0, cs, 1'b0, m, 1'b1});
    for (k = 0; k < 8000; k++) begin
      apb(1'b0, REG_STATUS, 32'h0);
      if (rdVal[ST_DONE] === 1'b1) break;
    end
    if (k == 8000) begin
      err_count++;
      end_sim();
    end
  endtask

  // wait for writeBusy to reach a level, bounded
  task automatic wait_busy(input logic lvl, input int lim);
    int k;
    for (k = 0; k < lim; k++) begin
      @(posedge ref_clk);
      if (writeBusy === lvl) break;
    end
    chk_bit("writeBusy", lvl, writeBusy);
    // a wait that ran out goes straight to the report
    if (writeBusy !== lvl) begin
      end_sim();
    end
  endtask

  initial begin
    ref_clk = 1'b0;
    reset_n = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    csPins = 3'h5;
    writeProtect = 1'b0;
    err_count = 0;
    tests_run = 0;
    repeat (4) @(posedge ref_clk);
    reset_n <= 1'b1;
    repeat (4) @(posedge ref_clk);
    chk_bit("standby", 1'b1, standby);
    chk_bit("writeBusy", 1'b0, writeBusy);
    $display("test reset ended");
    // lower array stays writable with protect high
    writeProtect <= 1'b1;
    run_op(MODE_WRITE, 3'h5, 12'h123, 8'h5a);
    chk_word("write status", 32'h4, rdVal);
    wait_busy(1'b1, 50);
    run_op(MODE_CREAD, 3'h5, 12'h000, 8'h00);
    chk_word("poll status", 32'h6, rdVal);
    wait_busy(1'b0, WR_CYC + 100);
    repeat (4) @(posedge ref_clk);
    chk_bit("standby", 1'b1, standby);
    $display("test write and poll ended");
    run_op(MODE_RREAD, 3'h5, 12'h123, 8'h00);
    chk_word("read status", 32'h4, rdVal);
    apb(1'b0, REG_RDATA, 32'h0);
    chk_word("read data", 32'h5a, rdVal);
    $display("test random read ended");
    run_op(MODE_WRITE, 3'h6, 12'h040, 8'h11);
    chk_word("mismatch status", 32'h6, rdVal);
    chk_bit("standby", 1'b1, standby);
    $display("test select mismatch ended");
    run_op(MODE_WRITE, 3'h5, 12'hc05, 8'h33);
    chk_word("protect status", 32'h4, rdVal);
    repeat (20) @(posedge ref_clk);
    chk_bit("writeBusy", 1'b0, writeBusy);
    writeProtect <= 1'b0;
    $display("test protect ended");
    run_op(MODE_RECOV, 3'h5, 12'h000, 8'h00);
    chk_word("recovery status", 32'h4, rdVal);
    chk_bit("standby", 1'b1, standby);
    $display("test recovery ended");
    apb(1'b0, 8'h14, 32'h0);
    chk_bit("pslverr", 1'b1, rdErr);
    chk_word("unmapped data", 32'h0, rdVal);
    $display("test unmapped ended");
    end_sim();
  end
endmodule
